// ==== hdl/phy_cfg_pkg.sv ====
// Purpose: shared constants of the phy test, preamble and link-drop register bank
// Assumes: 32-bit axi4-lite data, register index times four is the byte address
// Notes:   sixteen-bit registers sit in the low half of each word
package phy_cfg_pkg;
  // ----------------------------------------------------------------
  // register indices and address width
  // ----------------------------------------------------------------
  localparam logic [15:0] compliance_test_select_idx    = 16'h0027;
  localparam logic [15:0] ten_meg_config_idx            = 16'h002a;
  localparam logic [15:0] fast_link_drop_config_one_idx = 16'h0117;
  localparam logic [15:0] irq_status_idx                = 16'h0180;
  localparam logic [15:0] irq_mask_idx                  = 16'h0181;
  localparam logic [15:0] tx100_pattern_ctrl_idx        = 16'h0428;
  localparam int          addr_w                        = 16;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          test_enable_bit   = 4;
  localparam int          tx100_load_bit    = 4;
  localparam int          tx100_extra_bit   = 5;
  localparam int          preamble_sel_bit  = 14;
  localparam int          win_len_lsb       = 10;
  localparam int          drop_thr_lsb      = 4;
  localparam int          field6_w          = 6;
  localparam logic [15:0] compliance_reset  = 16'h0000;
  localparam logic [15:0] ten_meg_reset     = 16'h4000;
  localparam logic [15:0] fld_cfg_reset     = 16'h0000;
  localparam logic [15:0] tx100_ctrl_reset  = 16'h0000;
  localparam logic [3:0]  irq_reset         = 4'h0;
  // ----------------------------------------------------------------
  // preamble and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  preamble_byte     = 8'h55;
  localparam logic [7:0]  sfd_byte          = 8'hd5;
  localparam logic [3:0]  long_preamble_max = 4'h7;
  localparam logic [3:0]  short_preamble_gt = 4'h3;
  localparam int          clk_period_ns     = 10;
  localparam int          ten_meg_bit_ns    = 100;
  localparam int          bit_div           = ten_meg_bit_ns / clk_period_ns;
  // ----------------------------------------------------------------
  // line symbols and pattern codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    sym_idle = 3'b000, sym_one = 3'b001, sym_zero = 3'b010, sym_nlp = 3'b011,
    sym_tp_idle_00 = 3'b100, sym_tp_idle_01 = 3'b101, sym_tp_idle_10 = 3'b110
  } line_sym_type;
  localparam logic [3:0] pat_nlp = 4'h0, pat_one = 4'h1, pat_zero = 4'h2, pat_rep_one = 4'h3;
  localparam logic [3:0] pat_rep_zero = 4'h4, pat_zero_idle = 4'h6, pat_one_idle = 4'h7;
  localparam logic [3:0] pat_1001 = 4'h8, pat_random = 4'h9, pat_idle00 = 4'ha;
  localparam logic [3:0] pat_idle01 = 4'hb, pat_idle10 = 4'hc;
endpackage

// ==== hdl/pattern_cfg_if.sv ====
`timescale 1ns/10ps
// Purpose: carries the test pattern settings from the register bank to the generator
// Assumes: one clock domain
// Notes:   done is a one-cycle pulse back to the bank
interface pattern_cfg_if;
  logic       test_en;
  logic       speed_100;
  logic [3:0] pat10;
  logic [4:0] pat100;
  logic       load100;
  logic       done;
  modport bank (output test_en, output speed_100, output pat10, output pat100, output load100, input done);
  modport gen  (input test_en, input speed_100, input pat10, input pat100, input load100, output done);
endinterface

// ==== hdl/test_pattern_gen.sv ====
`timescale 1ns/10ps
// Purpose: compliance test symbol source for 10 and 100 mbit test modes
// Assumes: line driver consumes one symbol per bit enable
// Notes:   single patterns end in idle and pulse done once
module test_pattern_gen
  import phy_cfg_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // settings
  pattern_cfg_if.gen         cfg,
  // line side
  output line_sym_type       line_sym_q
);
  logic [3:0]  div_q;
  logic        bit_en;
  logic        sent_q;
  logic [1:0]  phase_q;
  logic [14:0] lfsr_q;
  logic [31:0] shift_q;
  logic [4:0]  pos_q;
  logic        done_q;
  logic [3:0]  code_q;

  assign bit_en   = (div_q == 4'(bit_div - 1));
  assign cfg.done = done_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || div_q == 4'(bit_div - 1)) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // 100 mbit shift register: a one then pat100 zeros
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg.pat100 == 5'h00) begin
      shift_q <= 32'h0;
      pos_q   <= 5'h0;
    end else if (cfg.load100) begin
      shift_q <= 32'h1;
      pos_q   <= 5'h0;
    end else if (bit_en) begin
      pos_q   <= (pos_q >= cfg.pat100) ? 5'h0 : pos_q + 5'h1;
    end
  end

  // ----------------------------------------------------------------
  // symbol selection
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.test_en) begin
      line_sym_q <= sym_idle;
      sent_q     <= 1'b0;
      phase_q    <= 2'h0;
      lfsr_q     <= 15'h7fff;
      done_q     <= 1'b0;
      code_q     <= 4'h0;
    end else begin
      done_q <= 1'b0;
      if (cfg.pat10 != code_q) begin
        // a new code re-arms the single patterns
        sent_q <= 1'b0;
        code_q <= cfg.pat10;
      end else if (bit_en) begin
        phase_q <= phase_q + 2'h1;
        lfsr_q  <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
        if (cfg.speed_100) begin
          line_sym_q <= (shift_q[0] && pos_q == 5'h0) ? sym_one : sym_zero;
        end else begin
          unique case (cfg.pat10)
            pat_nlp, pat_one, pat_zero: begin
              line_sym_q <= sent_q ? sym_idle
                          : (cfg.pat10 == pat_nlp) ? sym_nlp
                          : (cfg.pat10 == pat_one) ? sym_one : sym_zero;
              sent_q     <= 1'b1;
              done_q     <= !sent_q;
            end
            pat_zero_idle, pat_one_idle: begin
              line_sym_q <= sent_q ? sym_tp_idle_00 : (cfg.pat10 == pat_one_idle) ? sym_one : sym_zero;
              sent_q     <= 1'b1;
              done_q     <= !sent_q;
            end
            pat_rep_one:  line_sym_q <= sym_one;
            pat_rep_zero: line_sym_q <= sym_zero;
            pat_1001:     line_sym_q <= (phase_q == 2'h0 || phase_q == 2'h3) ? sym_one : sym_zero;
            pat_random:   line_sym_q <= lfsr_q[0] ? sym_one : sym_zero;
            pat_idle00:   line_sym_q <= sym_tp_idle_00;
            pat_idle01:   line_sym_q <= sym_tp_idle_01;
            pat_idle10:   line_sym_q <= sym_tp_idle_10;
            default:      line_sym_q <= sym_idle;
          endcase
        end
      end
    end
  end
endmodule

// ==== hdl/fast_link_drop.sv ====
`timescale 1ns/10ps
// Purpose: counts line code errors inside a window and flags link down
// Assumes: err pulses are one cycle, window counts core clock cycles
// Notes:   a zero window or zero threshold disables detection
module fast_link_drop
  import phy_cfg_pkg::*;
#(
  parameter int cnt_w = field6_w
)(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // settings
  input  wire logic [cnt_w-1:0] win_len,
  input  wire logic [cnt_w-1:0] drop_thr,
  // receiver status
  input  wire logic             rx_steady,
  input  wire logic             line_err,
  // result
  output logic                  drop_q
);
  if (cnt_w < 1 || cnt_w > 16) begin : g_bad_width
    $error("cnt_w out of range");
  end
  logic [cnt_w-1:0] win_q;
  logic [cnt_w-1:0] err_q;
  logic             armed;
  logic             count;

  assign armed = (win_len != '0) && (drop_thr != '0);
  assign count = armed && rx_steady;

  always_ff @(posedge aclk) begin
    if (!aresetn || !count) begin
      win_q  <= '0;
      err_q  <= '0;
      drop_q <= 1'b0;
    end else begin
      drop_q <= 1'b0;
      if (win_q >= win_len - 1'b1) begin
        win_q <= '0;
        err_q <= '0;
      end else begin
        win_q <= win_q + 1'b1;
        if (line_err) begin
          err_q <= err_q + 1'b1;
        end
      end
      if (line_err && err_q + 1'b1 == drop_thr) begin
        drop_q <= 1'b1;
      end
    end
  end
endmodule

// ==== hdl/phy_test_preamble_linkdrop_cfg.sv ====
// Purpose: axi4-lite register bank for compliance test, preamble mode and fast link drop
// Assumes: all inputs synchronous to aclk, one outstanding write and read
// Notes:   sixteen-bit registers in the low half of each word, upper half reads zero
`timescale 1ns/10ps
module phy_test_preamble_linkdrop_cfg
  import phy_cfg_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [addr_w-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [addr_w-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // phy status
  input  wire logic              speed_100,
  input  wire logic              rx_steady,
  input  wire logic              line_err,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  // outputs
  output line_sym_type           line_sym,
  output logic                   link_down,
  output logic                   preamble_valid,
  output logic                   irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]       compliance_q;
  logic [15:0]       ten_meg_q;
  logic [15:0]       fld_cfg_q;
  logic [15:0]       tx100_ctrl_q;
  logic [3:0]        status_q;
  logic [3:0]        mask_q;
  logic [3:0]        events;
  logic              load_prev_q;
  logic              irq_q;
  logic              pre_ok_q;
  logic              pre_bad_q;
  logic [3:0]        pre_cnt_q;
  logic              drop_pulse;
  logic              link_down_q;
  pattern_cfg_if     pcfg ();

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic              aw_held_q;
  logic              w_held_q;
  logic [addr_w-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_go;
  logic [15:0]       wr_idx;
  logic              wr_hit;
  logic [15:0]       wr_mask;

  assign wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx  = {2'b00, aw_addr_q[addr_w-1:2]};
  assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_hit  = wr_go && aw_addr_q[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      s_axi_wready  <= !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[1:0] == 2'b00) &&
                        (wr_idx == compliance_test_select_idx || wr_idx == ten_meg_config_idx ||
                         wr_idx == fast_link_drop_config_one_idx || wr_idx == irq_status_idx ||
                         wr_idx == irq_mask_idx || wr_idx == tx100_pattern_ctrl_idx) ? 2'b00 : 2'b10;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compliance_q <= compliance_reset;
      ten_meg_q    <= ten_meg_reset;
      fld_cfg_q    <= fld_cfg_reset;
      tx100_ctrl_q <= tx100_ctrl_reset;
      mask_q       <= irq_reset;
    end else if (wr_hit) begin
      // reserved bits are kept at zero so they always read back as zero
      unique case (wr_idx)
        compliance_test_select_idx:
          compliance_q <= (compliance_q & ~wr_mask) | (w_data_q[15:0] & wr_mask & 16'h001f);
        ten_meg_config_idx:
          ten_meg_q    <= (ten_meg_q & ~wr_mask) | (w_data_q[15:0] & wr_mask & 16'h4000);
        fast_link_drop_config_one_idx:
          fld_cfg_q    <= (fld_cfg_q & ~wr_mask) | (w_data_q[15:0] & wr_mask & 16'hfff0);
        tx100_pattern_ctrl_idx:
          tx100_ctrl_q <= (tx100_ctrl_q & ~wr_mask) | (w_data_q[15:0] & wr_mask & 16'h0030);
        irq_mask_idx:
          mask_q       <= w_strb_q[0] ? w_data_q[3:0] : mask_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pattern generator hookup
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= tx100_ctrl_q[tx100_load_bit];
    end
  end

  assign pcfg.test_en   = compliance_q[test_enable_bit];
  assign pcfg.speed_100 = speed_100;
  assign pcfg.pat10     = compliance_q[3:0];
  assign pcfg.pat100    = {tx100_ctrl_q[tx100_extra_bit], compliance_q[3:0]};
  // a new pattern loads only on the clear-then-set of the load bit
  assign pcfg.load100   = tx100_ctrl_q[tx100_load_bit] && !load_prev_q;

  test_pattern_gen u_gen (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cfg        (pcfg.gen),
    .line_sym_q (line_sym)
  );

  // ----------------------------------------------------------------
  // ten meg preamble check
  // ----------------------------------------------------------------
  logic short_mode;
  assign short_mode = ten_meg_q[preamble_sel_bit];

  always_ff @(posedge aclk) begin
    if (!aresetn || speed_100) begin
      pre_cnt_q <= 4'h0;
      pre_ok_q  <= 1'b0;
      pre_bad_q <= 1'b0;
    end else begin
      pre_ok_q  <= 1'b0;
      pre_bad_q <= 1'b0;
      if (rx_byte_valid) begin
        if (rx_byte == preamble_byte) begin
          // saturate: long mode looks at no more than seven bytes
          if (pre_cnt_q != long_preamble_max) begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
          end
        end else begin
          pre_cnt_q <= 4'h0;
          if (rx_byte == sfd_byte) begin
            if (short_mode ? (pre_cnt_q > short_preamble_gt) : (pre_cnt_q != 4'h0)) begin
              pre_ok_q  <= 1'b1;
            end else begin
              pre_bad_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  assign preamble_valid = pre_ok_q;

  // ----------------------------------------------------------------
  // fast link drop
  // ----------------------------------------------------------------
  fast_link_drop #(.cnt_w(field6_w)) u_fld (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .win_len   (fld_cfg_q[win_len_lsb +: field6_w]),
    .drop_thr  (fld_cfg_q[drop_thr_lsb +: field6_w]),
    .rx_steady (rx_steady),
    .line_err  (line_err),
    .drop_q    (drop_pulse)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_steady) begin
      link_down_q <= 1'b0;
    end else if (drop_pulse) begin
      link_down_q <= 1'b1;
    end
  end
  assign link_down = link_down_q;

  // ----------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  assign events = {pcfg.done, pre_bad_q, pre_ok_q, drop_pulse};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= irq_reset;
    end else if (wr_hit && wr_idx == irq_status_idx && w_strb_q[0]) begin
      status_q <= (status_q & ~w_data_q[3:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [15:0] rd_idx;
  logic [15:0] rd_val;
  logic        rd_ok;

  assign rd_idx = {2'b00, s_axi_araddr[addr_w-1:2]};

  always_comb begin
    rd_val = 16'h0;
    rd_ok  = s_axi_araddr[1:0] == 2'b00;
    unique case (rd_idx)
      compliance_test_select_idx:    rd_val = compliance_q;
      ten_meg_config_idx:            rd_val = ten_meg_q;
      fast_link_drop_config_one_idx: rd_val = fld_cfg_q;
      tx100_pattern_ctrl_idx:        rd_val = tx100_ctrl_q;
      irq_status_idx:                rd_val = {12'h000, status_q};
      irq_mask_idx:                  rd_val = {12'h000, mask_q};
      default:                       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_ok ? rd_val : 16'h0000};
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_test_off_idle: assert property (!compliance_q[test_enable_bit] |=> line_sym == sym_idle)
    else $error("line not idle with test modes off");
  chk_pattern_field: assert property (compliance_q[15:5] == 11'h000)
    else $error("compliance reserved bits set");
  chk_preamble_bit: assert property (ten_meg_q[13:0] == 14'h0 && ten_meg_q[15] == 1'b0)
    else $error("preamble register reserved bits set");
  chk_short_rejects: assert property (pre_ok_q && short_mode && !$past(speed_100) |->
                                      $past(pre_cnt_q) > short_preamble_gt)
    else $error("short mode accepted a short preamble");
  chk_long_cap: assert property (pre_cnt_q <= long_preamble_max)
    else $error("preamble count above seven");
  chk_speed_no_pre: assert property (speed_100 |=> !pre_ok_q && !pre_bad_q)
    else $error("preamble check active at 100 mbit");
  chk_no_drop_idle: assert property (!rx_steady |=> !drop_pulse)
    else $error("link drop outside steady state");
  chk_drop_disabled: assert property (fld_cfg_q[drop_thr_lsb +: field6_w] == 6'h0 |=> !drop_pulse)
    else $error("link drop with zero threshold");
  chk_drop_latch: assert property (drop_pulse && rx_steady |=> link_down)
    else $error("link down not raised");
  chk_load_edge: assert property (pcfg.load100 |=> !pcfg.load100)
    else $error("pattern load held longer than one cycle");
  chk_irq_follow: assert property (|(status_q & mask_q) |=> irq)
    else $error("interrupt not raised");

  cov_drop:     cover property (drop_pulse);
  cov_pre_ok:   cover property (pre_ok_q && !short_mode);
  cov_test_one: cover property (compliance_q[test_enable_bit] && line_sym == sym_one);
endmodule

// ==== testbench/link_partner_model.sv ====
// Purpose: link partner sending 10 mbit preambles and line code errors
// Assumes: one byte per strobe, errors are one-cycle pulses
// Notes:   data lines show the inverted last byte between strobes
`timescale 1ns/10ps
module link_partner_model
  import phy_cfg_pkg::*;
(
  // clock
  input  wire logic aclk,
  // receive side of the phy
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic       line_err
);
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    line_err = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge aclk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    repeat (bit_div) @(posedge aclk);
  endtask
  // short preambles probe the mode choice
  task automatic send_frame(input int n);
    repeat (n) send_byte(preamble_byte);
    send_byte(sfd_byte);
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge aclk);
      line_err <= 1'b1;
      @(posedge aclk);
      line_err <= 1'b0;
    end
  endtask
endmodule

// ==== testbench/phy_test_preamble_linkdrop_cfg_test.sv ====
// Purpose: axi4-lite test of the phy config bank
// Assumes: answers come well within the timeout
// Notes:   a mask bit of one lets its status bit raise irq
`timescale 1ns/10ps
module phy_test_preamble_linkdrop_cfg_test
  import phy_cfg_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, speed_100, rx_steady;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rd, rdata;
  logic [3:0] wstrb;
  logic [1:0] rs, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, link_down, preamble_valid, irq, rx_byte_valid, line_err;
  logic [7:0] rx_byte;
  line_sym_type line_sym;
  int err_total, num_checks, cyc, pv_cnt;
  logic [3:0] pcode [4] = '{pat_rep_one, pat_idle00, pat_idle01, pat_idle10};
  line_sym_type psym [4] = '{sym_one, sym_tp_idle_00, sym_tp_idle_01, sym_tp_idle_10};
  phy_test_preamble_linkdrop_cfg dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .speed_100(speed_100), .rx_steady(rx_steady), .line_err(line_err), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .line_sym(line_sym), .link_down(link_down), .preamble_valid(preamble_valid), .irq(irq));
  link_partner_model lp (.aclk(aclk), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .line_err(line_err));
  // ----
  // bus tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= {i[13:0], 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      a = a | awready;
      w = w | wready;
      awvalid <= !a;
      wvalid <= !w;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] i);
    @(posedge aclk);
    araddr <= {i[13:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [15:0] i, input logic [31:0] e);
    rdr(i);
    chk(n, e, rd);
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wsym(input line_sym_type e);
    for (int k = 0; k < 40 && line_sym !== e; k++) @(negedge aclk);
    chk("line symbol", {29'h0, e}, {29'h0, line_sym});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // clock, counters and sequence
  // ----
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (preamble_valid === 1'b1) pv_cnt++;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, speed_100, rx_steady, awaddr, araddr, wdata} = '0;
    wstrb = 4'h3;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("compliance reset", compliance_test_select_idx, 32'h0);
    rchk("ten meg reset", ten_meg_config_idx, 32'h4000);
    rchk("drop cfg reset", fast_link_drop_config_one_idx, 32'h0);
    rdr(16'h0100);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    wr(16'h0100, 16'h1234);
    chk("unmapped bresp", 32'h2, {30'h0, rs});
    wr(ten_meg_config_idx, 16'hffff);
    rchk("ten meg rw", ten_meg_config_idx, 32'h4000);
    wr(fast_link_drop_config_one_idx, 16'hfc3f);
    rchk("drop cfg rw", fast_link_drop_config_one_idx, 32'hfc30);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      wr(ten_meg_config_idx, k == 2 ? 16'h0000 : 16'h4000);
      lp.send_frame(k == 1 ? 4 : 2);
      rchk("preamble status", irq_status_idx, k == 0 ? 32'h4 : 32'h2);
      wr(irq_status_idx, 16'h000f);
    end
    chk("preamble pulses", 32'd2, pv_cnt);
    $display("test preamble done");
    lp.errs(6);
    settle();
    chk("drop unsteady", 32'h0, {31'h0, link_down});
    rx_steady <= 1'b1;
    lp.errs(2);
    settle();
    chk("drop below", 32'h0, {31'h0, link_down});
    lp.errs(4);
    settle();
    chk("drop reached", 32'h1, {31'h0, link_down});
    wr(irq_mask_idx, 16'h000f);
    settle();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(irq_mask_idx, 16'h0000);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("drop status", irq_status_idx, 32'h1);
    wr(irq_mask_idx, 16'h000f);
    wr(irq_status_idx, 16'h000f);
    settle();
    chk("irq clear", 32'h0, {31'h0, irq});
    rx_steady <= 1'b0;
    settle();
    chk("drop release", 32'h0, {31'h0, link_down});
    $display("test link drop done");
    for (int k = 0; k < 4; k++) begin
      wr(compliance_test_select_idx, {12'h001, pcode[k]});
      wsym(psym[k]);
    end
    wr(compliance_test_select_idx, {12'h001, pat_one_idle});
    wsym(sym_one);
    wsym(sym_tp_idle_00);
    rchk("pattern done", irq_status_idx, 32'h8);
    wr(compliance_test_select_idx, 16'hffe3);
    rchk("compliance rw", compliance_test_select_idx, 32'h3);
    wsym(sym_idle);
    $display("test patterns done");
    @(posedge aclk) speed_100 <= 1'b1;
    wr(tx100_pattern_ctrl_idx, 16'h0000);
    wr(compliance_test_select_idx, 16'h0012);
    wr(tx100_pattern_ctrl_idx, 16'h0010);
    wsym(sym_one);
    for (int k = 1; k < 8; k++) begin
      if (k == 4) wr(compliance_test_select_idx, 16'h0010);
      repeat (k < 4 ? 10 : 11) @(negedge aclk);
      chk("tx100 symbol", k == 3 ? 32'(sym_one) : 32'(sym_zero), 32'(line_sym));
    end
    $display("test tx100 done");
    test_done();
  end
endmodule
